// ==== hdl/led_key_pkg.sv ====
/*
  Shared constants and types for the front-panel LED and key-repeat block:
  register map, field positions, reset values, timing figures and modes.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port.
*/
`default_nettype none
package led_key_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] LOOK_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] TIMEOUT_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] CMD_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h10;
  // control register fields
  localparam int FUNC_LSB = 0;
  localparam int COLOUR_LSB = 4;
  localparam int BRIGHT_LSB = 8;
  localparam int QTY_LSB = 16;
  // look register: four 8-bit looks (ccw, cw, input low, input high)
  localparam int LOOK_STRIDE = 8;
  localparam int LOOK_PAT_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_ff00;
  localparam logic [31:0] LOOK_RST = 32'h0000_0000;
  localparam logic [14:0] TIMEOUT_RST = 15'h0000;
  localparam logic [14:0] TIMEOUT_MAX_S = 15'd18000;
  // timing: one tick is one millisecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [9:0] TICKS_PER_SEC = 10'd1000;
  localparam logic [9:0] HOLD_MS = 10'd1000;
  localparam logic [9:0] REPEAT_MS = 10'd100;
  localparam logic [9:0] FAST_MS = 10'd125;
  localparam logic [9:0] SLOW_MS = 10'd500;
  localparam logic [4:0] FLASH_MS = 5'd20;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    FN_DEVICE_ON, FN_REMOTE, FN_ROTATION, FN_ENERGY, FN_CMD, FN_INPUT
  } func_t;
  typedef enum logic [2:0] {
    PAT_OFF, PAT_ON, PAT_FAST, PAT_SLOW, PAT_BREATHE_FAST, PAT_BREATHE_SLOW
  } pattern_t;
  typedef enum logic [2:0] {
    COL_WHITE, COL_YELLOW, COL_GREEN, COL_BLUE, COL_RED, COL_ORANGE, COL_CYAN, COL_VIOLET
  } colour_t;
  typedef struct packed {
    logic pad;
    logic [2:0] pattern;
    logic pad2;
    logic [2:0] colour;
  } look_t;
endpackage
`default_nettype wire

// ==== hdl/status_led_and_key_repeat.sv ====
/*
  Front-panel indicator and key autorepeat logic: one RGB LED driven by a
  selectable function, pattern, colour and brightness, plus key repeat.
  Assumes pins arrive asynchronously, energy steps are one-cycle pulses on
  this clock (one per thousandth of a unit) and an AXI4-Lite master.
*/
// Local design decisions: the register offsets and the AXI4-Lite slave port.
// Function
// - a short press fires once; after about 1 s held, it repeats while held
// - power-on function ramps LED brightness smoothly up and down
// - remote function lights LED while remote active, off after timeout
// - remote timeout zero never expires; LED follows remote activity
// - rotation function uses separate colour and pattern per direction
// - patterns: off, on, fast or slow flash, flash with varying brightness
// - energy function flashes once per thousandth unit of chosen quantity; steps under 20 ms apart merge into one flash
// - command function: on command lights, off command or timeout darkens
// - command timeout zero keeps LED lit until off command
// - input function follows discrete input with per-state colour and pattern
// - user selects function, one of eight colours and brightness
`default_nettype none
module status_led_and_key_repeat
  import led_key_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] keyPressed,
  input wire logic remoteActive,
  input wire logic rotationCw,
  input wire logic discrete_input_state,
  input wire logic [3:0] energyStep,
  output logic [3:0] keyFire,
  output logic ledRed,
  output logic ledGreen,
  output logic ledBlue
);
  logic [31:0] ctrl_q;
  logic [31:0] look_q;
  logic [14:0] timeout_q;
  logic [ADDR_W-1:0] wAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic [6:0] prev_q;
  logic [16:0] tickCnt_q;
  logic msTick;
  logic [9:0] msCnt_q;
  logic secTick;
  logic [9:0] fastCnt_q;
  logic [9:0] slowCnt_q;
  logic fastPh_q;
  logic slowPh_q;
  logic [7:0] breath_q;
  logic breathUp_q;
  logic [14:0] remSec_q;
  logic remoteLit;
  logic cmdOn_q;
  logic [14:0] cmdSec_q;
  logic cmdExpire;
  logic [4:0] flash_q;
  logic [7:0] pwm_q;
  func_t fn;
  colour_t col;
  look_t look;
  logic [7:0] lvl;
  logic [15:0] scaled;
  logic [7:0] eff;
  logic [31:0] readVal;
  logic readOk;

  assign fn = func_t'(ctrl_q[FUNC_LSB +: 3]);
  assign doWrite = !awready && !wready && !bvalid;
  // write channel: address and data captured independently
  always_ff @(posedge clock) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else begin
      if (awvalid && awready) begin
        wAddr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_q <= wdata;
        wStrb_q <= wstrb;
        wready <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= (wAddr_q == CTRL_OFF || wAddr_q == LOOK_OFF || wAddr_q == TIMEOUT_OFF ||
                  wAddr_q == CMD_OFF) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end
  // configuration registers, byte lanes honoured
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      look_q <= LOOK_RST;
    end else if (doWrite) begin
      for (int b = 0; b < 4; b++) begin
        if (wStrb_q[b] && wAddr_q == CTRL_OFF) begin
          ctrl_q[b*8 +: 8] <= wData_q[b*8 +: 8];
        end
        if (wStrb_q[b] && wAddr_q == LOOK_OFF) begin
          look_q[b*8 +: 8] <= wData_q[b*8 +: 8];
        end
      end
    end
  end
  // timeout clamps to the largest legal figure
  always_ff @(posedge clock) begin
    if (rst) begin
      timeout_q <= TIMEOUT_RST;
    end else if (doWrite && wAddr_q == TIMEOUT_OFF && wStrb_q[1:0] == 2'b11) begin
      timeout_q <= (wData_q[31:0] > 32'(TIMEOUT_MAX_S)) ? TIMEOUT_MAX_S : wData_q[14:0];
    end
  end

  always_comb begin
    readOk = 1'b1;
    readVal = '0;
    unique case (araddr)
      CTRL_OFF: readVal = ctrl_q;
      LOOK_OFF: readVal = look_q;
      TIMEOUT_OFF: readVal = {17'h00000, timeout_q};
      CMD_OFF: readVal = {31'h00000000, cmdOn_q};
      STATUS_OFF: readVal = {20'h00000, sync2_q[6:3], 3'h0, sync2_q[1], sync2_q[0],
                             cmdOn_q, remoteLit, (eff != 8'h00)};
      default: readOk = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= readVal;
      rresp <= readOk ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
  // pin synchronisers: {keys, remote, input, rotation}
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= {keyPressed, remoteActive, discrete_input_state, rotationCw};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  // millisecond and second ticks
  always_ff @(posedge clock) begin
    if (rst || msTick) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + 17'd1;
    end
  end
  assign msTick = (tickCnt_q == 17'(TICK_LEN - 1));

  always_ff @(posedge clock) begin
    if (rst || secTick) begin
      msCnt_q <= '0;
    end else if (msTick) begin
      msCnt_q <= msCnt_q + 10'd1;
    end
  end
  assign secTick = msTick && (msCnt_q == TICKS_PER_SEC - 10'd1);
  // flash phases
  always_ff @(posedge clock) begin
    if (rst) begin
      fastCnt_q <= '0;
      slowCnt_q <= '0;
      fastPh_q <= 1'b0;
      slowPh_q <= 1'b0;
    end else if (msTick) begin
      fastCnt_q <= (fastCnt_q == FAST_MS - 10'd1) ? 10'd0 : fastCnt_q + 10'd1;
      slowCnt_q <= (slowCnt_q == SLOW_MS - 10'd1) ? 10'd0 : slowCnt_q + 10'd1;
      if (fastCnt_q == FAST_MS - 10'd1) begin
        fastPh_q <= !fastPh_q;
      end
      if (slowCnt_q == SLOW_MS - 10'd1) begin
        slowPh_q <= !slowPh_q;
      end
    end
  end
  // triangle ramp, one step per millisecond
  always_ff @(posedge clock) begin
    if (rst) begin
      breath_q <= '0;
      breathUp_q <= 1'b1;
    end else if (msTick) begin
      breath_q <= breathUp_q ? breath_q + 8'd1 : breath_q - 8'd1;
      if (breathUp_q && breath_q == 8'hfe) begin
        breathUp_q <= 1'b0;
      end else if (!breathUp_q && breath_q == 8'h01) begin
        breathUp_q <= 1'b1;
      end
    end
  end
  // remote-access timer restarts on each new activation
  always_ff @(posedge clock) begin
    if (rst) begin
      remSec_q <= '0;
    end else if (sync2_q[2] && !prev_q[2]) begin
      remSec_q <= '0;
    end else if (secTick && sync2_q[2] && remSec_q != TIMEOUT_MAX_S) begin
      remSec_q <= remSec_q + 15'd1;
    end
  end
  assign remoteLit = sync2_q[2] &&
                     (timeout_q == 15'd0 || remSec_q < timeout_q);
  // command-controlled state; an on command beats a same-cycle expiry
  assign cmdExpire = cmdOn_q && timeout_q != 15'd0 && cmdSec_q >= timeout_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      cmdOn_q <= 1'b0;
      cmdSec_q <= '0;
    end else if (doWrite && wAddr_q == CMD_OFF && wStrb_q[0] && wData_q[0]) begin
      cmdOn_q <= 1'b1;
      cmdSec_q <= '0;
    end else if ((doWrite && wAddr_q == CMD_OFF && wStrb_q[0]) || cmdExpire) begin
      cmdOn_q <= 1'b0;
    end else if (secTick && cmdOn_q) begin
      cmdSec_q <= cmdSec_q + 15'd1;
    end
  end
  // energy flash: a new step restarts the flash, so steps less than 20 ms apart merge into one flash
  always_ff @(posedge clock) begin
    if (rst) begin
      flash_q <= '0;
    end else if (energyStep[ctrl_q[QTY_LSB +: 2]]) begin
      flash_q <= FLASH_MS;
    end else if (msTick && flash_q != 5'd0) begin
      flash_q <= flash_q - 5'd1;
    end
  end

  function automatic logic [7:0] patLevel(input logic [2:0] pat);
    logic [7:0] v;
    v = 8'h00;
    unique case (pattern_t'(pat))
      PAT_OFF: v = 8'h00;
      PAT_ON: v = 8'hff;
      PAT_FAST: v = fastPh_q ? 8'hff : 8'h00;
      PAT_SLOW: v = slowPh_q ? 8'hff : 8'h00;
      PAT_BREATHE_FAST: v = fastPh_q ? breath_q : 8'h00;
      PAT_BREATHE_SLOW: v = slowPh_q ? breath_q : 8'h00;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // function selection
  always_comb begin
    col = colour_t'(ctrl_q[COLOUR_LSB +: 3]);
    look = '0;
    lvl = 8'h00;
    unique case (fn)
      FN_DEVICE_ON: lvl = breath_q;
      FN_REMOTE: lvl = remoteLit ? 8'hff : 8'h00;
      FN_ROTATION: begin
        look = look_q[(sync2_q[0] ? 1 : 0) * LOOK_STRIDE +: LOOK_STRIDE];
        col = colour_t'(look.colour);
        lvl = patLevel(look.pattern);
      end
      FN_ENERGY: lvl = (flash_q != 5'd0) ? 8'hff : 8'h00;
      FN_CMD: lvl = cmdOn_q ? 8'hff : 8'h00;
      FN_INPUT: begin
        look = look_q[(sync2_q[1] ? 3 : 2) * LOOK_STRIDE +: LOOK_STRIDE];
        col = colour_t'(look.colour);
        lvl = patLevel(look.pattern);
      end
      default: lvl = 8'h00;
    endcase
  end

  assign scaled = lvl * ctrl_q[BRIGHT_LSB +: 8];
  assign eff = scaled[15:8];

  always_ff @(posedge clock) begin
    if (rst) begin
      pwm_q <= '0;
    end else begin
      pwm_q <= pwm_q + 8'd1;
    end
  end

  // colour mixing; orange uses half-strength green
  always_ff @(posedge clock) begin
    if (rst) begin
      ledRed <= 1'b0;
      ledGreen <= 1'b0;
      ledBlue <= 1'b0;
    end else begin
      ledRed <= (pwm_q < eff) && (col inside {COL_WHITE, COL_YELLOW, COL_RED,
                                              COL_ORANGE, COL_VIOLET});
      ledGreen <= (col == COL_ORANGE) ? (pwm_q < {1'b0, eff[7:1]}) :
                  (pwm_q < eff) && (col inside {COL_WHITE, COL_YELLOW, COL_GREEN, COL_CYAN});
      ledBlue <= (pwm_q < eff) && (col inside {COL_WHITE, COL_BLUE, COL_CYAN, COL_VIOLET});
    end
  end

  // key autorepeat, one counter per key
  for (genvar k = 0; k < 4; k++) begin : gKey
    logic [9:0] held_q;
    always_ff @(posedge clock) begin
      if (rst) begin
        held_q <= '0;
        keyFire[k] <= 1'b0;
      end else if (!sync2_q[3 + k]) begin
        held_q <= '0;
        keyFire[k] <= 1'b0;
      end else if (!prev_q[3 + k]) begin
        held_q <= '0;
        keyFire[k] <= 1'b1;
      end else if (msTick && held_q == HOLD_MS - 10'd1) begin
        held_q <= HOLD_MS - REPEAT_MS;
        keyFire[k] <= 1'b1;
      end else begin
        held_q <= msTick ? held_q + 10'd1 : held_q;
        keyFire[k] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/led_key_props.sv ====
/*
  Checker for the LED and key-repeat block: bus handshakes, key pulses, LED reset.
  Assumes binding to the top module and its synchronous active-high reset.
*/
`default_nettype none
module led_key_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [3:0] keyPressed,
  input wire logic [3:0] keyFire,
  input wire logic ledRed,
  input wire logic ledGreen,
  input wire logic ledBlue
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_wr_answer;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_done;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write channel not reopened");
  property p_rd_answer;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_fire_pulse;
    keyFire[0] |=> !keyFire[0];
  endproperty
  a_fire_pulse: assert property (p_fire_pulse) else $error("key pulse too long");
  property p_fire_press;
    $rose(keyPressed[0]) |-> ##[1:6] keyFire[0];
  endproperty
  a_fire_press: assert property (p_fire_press) else $error("press not fired");
  property p_fire_idle;
    (!keyPressed[0]) [*5] |-> !keyFire[0];
  endproperty
  a_fire_idle: assert property (p_fire_idle) else $error("fire without key");
  property p_led_dark;
    $fell(rst) |-> !ledRed && !ledGreen && !ledBlue;
  endproperty
  a_led_dark: assert property (p_led_dark) else $error("led lit after reset");
  c_fire: cover property (keyFire[0]);
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
endmodule
bind status_led_and_key_repeat led_key_props u_props (.clock(clock), .rst(rst),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .keyPressed(keyPressed), .keyFire(keyFire),
  .ledRed(ledRed), .ledGreen(ledGreen), .ledBlue(ledBlue));
`default_nettype wire

// ==== dv/panel_model.sv ====
/*
  Front-panel keys, inputs and metering pulses seen by the block.
  Assumes its tasks are called just after a rising clock edge.
*/
`default_nettype none
module panel_model (
  input wire logic clock,
  output logic [3:0] keyPressed,
  output logic remoteActive,
  output logic rotationCw,
  output logic discrete_input_state,
  output logic [3:0] energyStep
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    keyPressed = 4'h0;
    remoteActive = 1'b0;
    rotationCw = 1'b0;
    discrete_input_state = 1'b0;
    energyStep = 4'h0;
  end
  task automatic hold_key(input int k, input int n);
    keyPressed[k] <= 1'b1;
    repeat (n) @(posedge clock);
    keyPressed[k] <= 1'b0;
  endtask
  // energy steps are single-cycle pulses, one per thousandth unit
  task automatic step(input int q);
    energyStep[q] <= 1'b1;
    @(posedge clock);
    energyStep[q] <= 1'b0;
  endtask
  task automatic levels(input logic r, input logic c, input logic d);
    remoteActive <= r;
    rotationCw <= c;
    discrete_input_state <= d;
  endtask
endmodule
`default_nettype wire

// ==== dv/status_led_and_key_repeat_test.sv ====
/*
  Self-checking bench: register access, key repeat, LED functions and timeouts.
  Assumes TICK_LEN of 10, so one millisecond is 10 cycles and one second 10000.
*/
`default_nettype none
module status_led_and_key_repeat_test
  import led_key_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'hf, keyPressed, energyStep, keyFire;
  logic awready, wready, bvalid, arready, rvalid, remoteActive, rotationCw, dis;
  logic ledRed, ledGreen, ledBlue;
  logic [1:0] bresp, rresp, resp;
  int bad_count = 0, check_count = 0, fires = 0, cyc = 0, nr, nb, ng, n1, n2;
  status_led_and_key_repeat #(.TICK_LEN(10)) dut (.clock(clock), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .keyPressed(keyPressed), .remoteActive(remoteActive),
    .rotationCw(rotationCw), .discrete_input_state(dis), .energyStep(energyStep),
    .keyFire(keyFire), .ledRed(ledRed), .ledGreen(ledGreen), .ledBlue(ledBlue));
  panel_model pm (.clock(clock), .keyPressed(keyPressed), .remoteActive(remoteActive),
    .rotationCw(rotationCw), .discrete_input_state(dis), .energyStep(energyStep));
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    if (keyFire[0] === 1'b1) fires++;
    cyc++;
    // ceiling sits well above the roughly 65000 cycles the sequence needs
    if (cyc == 90000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask
  // one full pwm period, so a steady level counts exactly as its drive value
  task automatic led_count();
    nr = 0;
    nb = 0;
    ng = 0;
    repeat (256) begin
      @(posedge clock);
      nr += (ledRed === 1'b1);
      nb += (ledBlue === 1'b1);
      ng += (ledGreen === 1'b1);
    end
  endtask
  task automatic wait_ms(input int n);
    repeat (n * 10) @(posedge clock);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(CTRL_OFF); chk("ctrlReset", rv, CTRL_RST);
    rd(LOOK_OFF); chk("lookReset", rv, LOOK_RST);
    rd(8'h14); chk("unmappedResp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    chk("unmappedData", rv, 32'h0);
    wr(STATUS_OFF, 32'h1); chk("statusWrResp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(TIMEOUT_OFF, 32'd20000); rd(TIMEOUT_OFF); chk("toClamp", rv, 32'd18000);
    fires = 0; pm.hold_key(0, 500); wait_ms(2); chk("shortFires", fires, 1);
    fires = 0; pm.hold_key(0, 13500); wait_ms(2); chk("heldFires", fires, 5);
    // rotation looks: ccw red steady, cw blue steady
    wr(LOOK_OFF, 32'h0000_1314);
    wr(CTRL_OFF, 32'h0000_ff02);
    pm.levels(1'b0, 1'b0, 1'b1); wait_ms(1); led_count();
    chk("ccwRed", nr > 0, 1); chk("ccwBlue", nb, 0);
    pm.levels(1'b0, 1'b1, 1'b1); wait_ms(1); led_count();
    chk("cwRed", nr, 0); chk("cwBlue", nb > 0, 1);
    rd(STATUS_OFF); chk("statusLevels", rv[4:3], 2'b11);
    // cw look becomes fast red flash; three samples one half period apart
    wr(LOOK_OFF, 32'h0000_2414); rd(STATUS_OFF); n1 = rv[0];
    wait_ms(125); rd(STATUS_OFF); n2 = rv[0];
    wait_ms(125); rd(STATUS_OFF);
    chk("fastFlash", (n1 != n2) || (n2 != rv[0]), 1'b1);
    wr(CTRL_OFF, CTRL_RST); led_count(); n1 = nr; led_count(); n2 = nr; led_count();
    chk("breathVaries", (n1 != n2) || (n2 != nr), 1'b1);
    wr(CTRL_OFF, 32'h0000_ff03); pm.step(0); wait_ms(1);
    rd(STATUS_OFF); chk("pulseLit", rv[0], 1'b1);
    wait_ms(30); rd(STATUS_OFF); chk("pulseDark", rv[0], 1'b0);
    wr(TIMEOUT_OFF, 32'd1); wr(CTRL_OFF, 32'h0000_ff01);
    pm.levels(1'b1, 1'b0, 1'b0); wait_ms(5);
    rd(STATUS_OFF); chk("remoteLit", rv[1], 1'b1);
    wait_ms(1200); rd(STATUS_OFF); chk("remoteExpired", rv[1], 1'b0);
    pm.levels(1'b0, 1'b0, 1'b0); wait_ms(1);
    pm.levels(1'b1, 1'b0, 1'b0); wait_ms(1);
    rd(STATUS_OFF); chk("remoteRestart", rv[1], 1'b1);
    pm.levels(1'b0, 1'b0, 1'b0); wr(TIMEOUT_OFF, 32'd0);
    pm.levels(1'b1, 1'b0, 1'b0); wait_ms(1100);
    rd(STATUS_OFF); chk("remoteNoExpiry", rv[1], 1'b1);
    pm.levels(1'b0, 1'b0, 1'b0); wait_ms(1);
    rd(STATUS_OFF); chk("remoteOff", rv[1], 1'b0);
    wr(CTRL_OFF, 32'h0000_ff04); wr(CMD_OFF, 32'h1); wait_ms(1100);
    rd(CMD_OFF); chk("cmdNoExpiry", rv[0], 1'b1);
    // orange is full red plus half green; drive value is level times brightness / 256
    wr(CTRL_OFF, 32'h0000_ff54); led_count();
    chk("orangeRed", nr, 254);
    chk("orangeGreen", ng, 127);
    chk("orangeBlue", nb, 0);
    wr(CTRL_OFF, 32'h0000_4054); led_count();
    chk("dimRed", nr, 63);
    chk("dimGreen", ng, 31);
    wr(CMD_OFF, 32'h0); rd(CMD_OFF); chk("cmdOff", rv[0], 1'b0);
    wr(TIMEOUT_OFF, 32'd1); wr(CMD_OFF, 32'h1);
    rd(CMD_OFF); chk("cmdOn", rv[0], 1'b1);
    wait_ms(1200); rd(CMD_OFF); chk("cmdExpired", rv[0], 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
